// [hdl/host_port_pin_interface.sv]
// parallel host port: pin handshake, strap enable, muxed and wide modes
`timescale 1ns/10ps

// What this block does
// - byte ident marks first or second byte; ignored in wide mode
// - address strobe latches the presented address into the address register
// - direction input decides whether data moves to or from the host
// - ready output tells the host when the next transfer may start
// - ready output floats while global output disable is low
// - host interrupt pin interrupts host, driven high during reset
// - disabled port may route second timer output onto interrupt pin
// - interrupt pin floats when output disable low; unused in wide mode
// - port enable strap is taken once the synchroniser has settled after reset release
// - strap low or open at reset disables the port
// - once disabled, strap changes are ignored until next reset
// - wide select high gives non-muxed mode with sixteen address pins
// - wide mode has no interrupts either way
// - wide mode has no control or address register
// - wide mode takes the address pins as internal memory addresses
// - wide mode turns the narrow data pins into general purpose pins
module host_port_pin_interface #(
  parameter int unsigned STRAP_SETTLE = hpi_pkg::STRAP_SETTLE
) (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  // host control pins
  input  wire logic        i_reg_select_bit0,
  input  wire logic        i_reg_select_bit1,
  input  wire logic        i_byte_order_ident,
  input  wire logic        i_port_chip_select_n,
  input  wire logic        i_data_strobe_a_n,
  input  wire logic        i_data_strobe_b_n,
  input  wire logic        i_addr_strobe_n,
  input  wire logic        i_transfer_direction,
  input  wire logic        i_port_enable_strap,
  input  wire logic        i_wide_mode_select,
  input  wire logic        i_outputs_off_n,
  input  wire logic [15:0] i_wide_address_pins,
  // narrow data pins
  input  wire logic [7:0]  i_narrow_host_data,
  output logic      [7:0]  o_narrow_host_data,
  output logic      [7:0]  o_narrow_host_data_oe_n,
  // wide data pins
  input  wire logic [15:0] i_wide_data,
  output logic      [15:0] o_wide_data,
  output logic             o_wide_data_oe_n,
  // ready and interrupt pins
  output logic             o_port_ready_out,
  output logic             o_port_ready_out_oe_n,
  output logic             o_host_interrupt_out,
  output logic             o_host_interrupt_out_oe_n,
  input  wire logic        i_second_timer_output,
  // internal memory port and DSP interrupt
  output logic             o_mem_req,
  output logic             o_mem_we,
  output logic      [15:0] o_mem_addr,
  output logic      [15:0] o_mem_wdata,
  input  wire logic        i_mem_ack,
  input  wire logic [15:0] i_mem_rdata,
  output logic             o_dsp_int,
  // register bus
  input  wire logic [1:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest
);
  localparam int unsigned PIN_W = 11 + 8 + 16 + 16;

  if (STRAP_SETTLE < 2 || STRAP_SETTLE > 7) begin : g_chk
    $error("STRAP_SETTLE must cover the synchroniser and fit three bits");
  end

  // synchronised pins
  logic [PIN_W-1:0] pins_q;
  logic cs_n_q, ds_a_n_q, ds_b_n_q, as_n_q, rw_q, sel1_q, sel0_q, bil_q;
  logic wide_q, strap_q, off_n_q;
  logic [7:0]  narrow_q;
  logic [15:0] wdata_q;
  logic [15:0] addr_q;

  pin_sync #(.WIDTH(PIN_W), .RESET_VAL('1)) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_port_chip_select_n, i_data_strobe_a_n, i_data_strobe_b_n,
                 i_addr_strobe_n, i_transfer_direction, i_reg_select_bit1,
                 i_reg_select_bit0, i_byte_order_ident, i_wide_mode_select,
                 i_port_enable_strap, i_outputs_off_n, i_narrow_host_data,
                 i_wide_data, i_wide_address_pins}),
    .o_sync    (pins_q)
  );
  assign {cs_n_q, ds_a_n_q, ds_b_n_q, as_n_q, rw_q, sel1_q, sel0_q, bil_q,
          wide_q, strap_q, off_n_q, narrow_q, wdata_q, addr_q} = pins_q;

  // state
  hpi_pkg::xfer_state_t state_r, state_nxt;
  logic [2:0]  strap_cnt_r;
  logic        cap_done_r, port_en_r;
  logic        xfer_prev_r, as_prev_r;
  logic        rw_r, rw_nxt, bil_r, bil_nxt;
  logic [1:0]  sel_r, sel_nxt;
  logic [15:0] rword_r, rword_nxt;
  logic [7:0]  hold_byte_r, hold_byte_nxt;
  logic [15:0] haddr_r, haddr_nxt;
  logic        req_nxt, we_nxt;
  logic [15:0] maddr_nxt, mwdata_nxt;
  logic        host_interrupt_out_flag_r, dspint_flag_r;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic        host_control_register_wr;

  // decode
  logic        mux_mode, wide_act, xfer_q, start, as_fall, is_data, need_mem;
  logic [1:0]  sel_q;
  logic [15:0] host_control_register_word, host_word;
  logic        route_en;
  logic [7:0]  gpio_out, gpio_dir;

  assign mux_mode = port_en_r && !wide_q;
  assign wide_act = port_en_r && wide_q;
  assign sel_q    = {sel1_q, sel0_q};
  assign xfer_q   = !cs_n_q && (!ds_a_n_q || !ds_b_n_q);
  assign start    = xfer_q && !xfer_prev_r && port_en_r && (state_r == hpi_pkg::ST_IDLE);
  // no address latch in wide mode
  assign as_fall  = !as_n_q && as_prev_r && mux_mode;
  assign is_data  = (sel_q == hpi_pkg::SEL_DATA_INC) || (sel_q == hpi_pkg::SEL_DATA);
  // reads fetch on first byte, writes store on second
  assign need_mem  = wide_q || (is_data && (rw_q ? !bil_q : bil_q));
  assign host_word = {hold_byte_r, narrow_q};
  assign route_en  = ctrl_r[hpi_pkg::CTRL_ROUTE_BIT];
  assign gpio_out  = ctrl_r[hpi_pkg::CTRL_GPIO_OUT_LSB +: 8];
  assign gpio_dir  = ctrl_r[hpi_pkg::CTRL_GPIO_DIR_LSB +: 8];

  always_comb begin
    host_control_register_word = '0;
    host_control_register_word[hpi_pkg::HOST_CONTROL_REGISTER_HOST_INTERRUPT_OUT_BIT]   = host_interrupt_out_flag_r;
    host_control_register_word[hpi_pkg::HOST_CONTROL_REGISTER_DSPINT_BIT] = dspint_flag_r;
  end

  // strap taken once the synchroniser has settled after release
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_cnt_r <= 3'h0;
      cap_done_r  <= 1'b0;
      port_en_r   <= 1'b0;
    end else if (!cap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 3'h1;
      if (strap_cnt_r == 3'(STRAP_SETTLE)) begin
        cap_done_r <= 1'b1;
        // low or open strap leaves port disabled
        port_en_r  <= strap_q;
      end
    end
  end

  // transfer sequencer
  always_comb begin
    state_nxt     = state_r;
    rw_nxt        = rw_r;
    sel_nxt       = sel_r;
    bil_nxt       = bil_r;
    rword_nxt     = rword_r;
    hold_byte_nxt = hold_byte_r;
    haddr_nxt     = haddr_r;
    req_nxt       = o_mem_req;
    we_nxt        = o_mem_we;
    maddr_nxt     = o_mem_addr;
    mwdata_nxt    = o_mem_wdata;
    host_control_register_wr       = 1'b0;
    unique case (state_r)
      hpi_pkg::ST_IDLE: begin
        if (start) begin
          rw_nxt  = rw_q;
          sel_nxt = sel_q;
          // byte ident ignored in wide mode
          bil_nxt = bil_q && !wide_q;
          if (need_mem) begin
            state_nxt  = hpi_pkg::ST_MEM;
            req_nxt    = 1'b1;
            we_nxt     = !rw_q;
            // wide mode addresses straight from pins
            maddr_nxt  = wide_q ? addr_q : haddr_r;
            mwdata_nxt = wide_q ? wdata_q : host_word;
          end else begin
            state_nxt = hpi_pkg::ST_HOLD;
            if (!rw_q) begin
              if (sel_q == hpi_pkg::SEL_ADDR) begin
                haddr_nxt = hpi_pkg::merge_byte(haddr_r, narrow_q, bil_q);
              end else if (sel_q == hpi_pkg::SEL_CTRL && bil_q) begin
                host_control_register_wr = 1'b1;
              end else begin
                hold_byte_nxt = narrow_q;
              end
            end else if (!is_data) begin
              rword_nxt = (sel_q == hpi_pkg::SEL_ADDR) ? haddr_r : host_control_register_word;
            end
          end
        end else if (as_fall) begin
          // address strobe latches the address byte
          haddr_nxt = hpi_pkg::merge_byte(haddr_r, narrow_q, bil_q);
        end
      end
      hpi_pkg::ST_MEM: begin
        if (i_mem_ack) begin
          req_nxt   = 1'b0;
          rword_nxt = i_mem_rdata;
          state_nxt = hpi_pkg::ST_HOLD;
        end
      end
      hpi_pkg::ST_HOLD: begin
        if (!xfer_q) begin
          state_nxt = hpi_pkg::ST_IDLE;
          if (!wide_q && bil_r && sel_r == hpi_pkg::SEL_DATA_INC) begin
            haddr_nxt = haddr_r + 16'h0001;
          end
        end
      end
      default: state_nxt = hpi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r     <= hpi_pkg::ST_IDLE;
      xfer_prev_r <= 1'b0;
      as_prev_r   <= 1'b1;
      rw_r        <= 1'b1;
      sel_r       <= hpi_pkg::SEL_CTRL;
      bil_r       <= 1'b0;
      rword_r     <= 16'h0000;
      hold_byte_r <= 8'h00;
      haddr_r     <= 16'h0000;
      o_mem_req   <= 1'b0;
      o_mem_we    <= 1'b0;
      o_mem_addr  <= 16'h0000;
      o_mem_wdata <= 16'h0000;
    end else begin
      state_r     <= state_nxt;
      xfer_prev_r <= xfer_q;
      as_prev_r   <= as_n_q;
      rw_r        <= rw_nxt;
      sel_r       <= sel_nxt;
      bil_r       <= bil_nxt;
      rword_r     <= rword_nxt;
      hold_byte_r <= hold_byte_nxt;
      haddr_r     <= haddr_nxt;
      o_mem_req   <= req_nxt;
      o_mem_we    <= we_nxt;
      o_mem_addr  <= maddr_nxt;
      o_mem_wdata <= mwdata_nxt;
    end
  end

  // register bus: one wait cycle, then a single-cycle answer
  logic avs_req, avs_take, wr_host_interrupt_out;
  logic [31:0] rd_mux, stat_word;
  assign avs_req  = i_avs_read || i_avs_write;
  assign avs_take = avs_req && !o_avs_waitrequest;
  assign wr_host_interrupt_out  = avs_take && i_avs_write && i_avs_address == hpi_pkg::REG_HOST_INTERRUPT_OUT
                    && i_avs_byteenable[0];

  always_comb begin
    stat_word = '0;
    stat_word[hpi_pkg::STAT_EN_BIT]   = port_en_r;
    stat_word[hpi_pkg::STAT_WIDE_BIT] = wide_q;
    stat_word[hpi_pkg::STAT_RDY_BIT]  = o_port_ready_out;
    stat_word[hpi_pkg::STAT_GPIO_LSB +: 8]  = narrow_q;
    stat_word[hpi_pkg::STAT_ADDR_LSB +: 16] = haddr_r;
    rd_mux = '0;
    if (i_avs_address == hpi_pkg::REG_CTRL) begin
      rd_mux = ctrl_r;
    end else if (i_avs_address == hpi_pkg::REG_HOST_INTERRUPT_OUT) begin
      rd_mux[hpi_pkg::HOST_INTERRUPT_OUT_FLAG_BIT]   = host_interrupt_out_flag_r;
      rd_mux[hpi_pkg::HOST_INTERRUPT_OUT_DSPINT_BIT] = dspint_flag_r;
    end else if (i_avs_address == hpi_pkg::REG_STAT) begin
      rd_mux = stat_word;
    end
    ctrl_nxt = ctrl_r;
    if (avs_take && i_avs_write && i_avs_address == hpi_pkg::REG_CTRL) begin
      for (int b = 0; b < 4; b++) begin
        if (i_avs_byteenable[b]) begin
          ctrl_nxt[8*b +: 8] = i_avs_writedata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0000_0000;
      ctrl_r            <= hpi_pkg::CTRL_RESET;
    end else begin
      o_avs_waitrequest <= !(avs_req && o_avs_waitrequest);
      if (i_avs_read && o_avs_waitrequest) begin
        o_avs_readdata <= rd_mux;
      end
      ctrl_r <= ctrl_nxt;
    end
  end

  // interrupt flags; a set in the clearing cycle wins
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_interrupt_out_flag_r   <= 1'b0;
      dspint_flag_r <= 1'b0;
    end else begin
      host_interrupt_out_flag_r   <= mux_mode && ((wr_host_interrupt_out && i_avs_writedata[hpi_pkg::HOST_INTERRUPT_OUT_FLAG_BIT])
                       || (host_interrupt_out_flag_r && !(host_control_register_wr && host_word[hpi_pkg::HOST_CONTROL_REGISTER_HOST_INTERRUPT_OUT_BIT])));
      dspint_flag_r <= mux_mode && ((host_control_register_wr && host_word[hpi_pkg::HOST_CONTROL_REGISTER_DSPINT_BIT])
                       || (dspint_flag_r && !(wr_host_interrupt_out
                       && i_avs_writedata[hpi_pkg::HOST_INTERRUPT_OUT_DSPINT_BIT])));
    end
  end

  // pin drivers; all registered, enables low while driving
  logic        rd_drive;
  logic        host_interrupt_out_pin_nxt, ready_nxt;
  logic [7:0]  narrow_out_nxt, narrow_oe_n_nxt;
  assign rd_drive  = off_n_q && (state_r == hpi_pkg::ST_HOLD) && rw_r && xfer_q;
  // not ready while a memory cycle is open
  assign ready_nxt = port_en_r && (state_nxt != hpi_pkg::ST_MEM);
  // timer routed only while port is disabled
  assign host_interrupt_out_pin_nxt = !cap_done_r ? 1'b1 :
                        port_en_r   ? (wide_q || !host_interrupt_out_flag_r) :
                        (route_en ? i_second_timer_output : 1'b1);
  // wide mode narrow pins act as general purpose pins
  assign narrow_out_nxt  = wide_act ? gpio_out : hpi_pkg::pick_byte(rword_r, bil_r);
  assign narrow_oe_n_nxt = wide_act ? ~(gpio_dir & {8{off_n_q}}) :
                           {8{!(mux_mode && rd_drive)}};

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_narrow_host_data        <= 8'h00;
      o_narrow_host_data_oe_n   <= 8'hff;
      o_wide_data               <= 16'h0000;
      o_wide_data_oe_n          <= 1'b1;
      o_port_ready_out          <= 1'b0;
      o_port_ready_out_oe_n     <= 1'b0;
      // interrupt pin driven high during reset
      o_host_interrupt_out      <= 1'b1;
      o_host_interrupt_out_oe_n <= 1'b0;
      o_dsp_int                 <= 1'b0;
    end else begin
      o_narrow_host_data        <= narrow_out_nxt;
      o_narrow_host_data_oe_n   <= narrow_oe_n_nxt;
      // wide mode moves 16-bit words on the wide pins
      o_wide_data               <= rword_r;
      o_wide_data_oe_n          <= !(wide_act && rd_drive);
      o_port_ready_out          <= ready_nxt;
      o_port_ready_out_oe_n     <= !off_n_q;
      o_host_interrupt_out      <= host_interrupt_out_pin_nxt;
      // interrupt pin floats under output disable
      o_host_interrupt_out_oe_n <= !off_n_q;
      o_dsp_int                 <= dspint_flag_r;
    end
  end

  // checks
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  ready_float_a: assert property (!off_n_q |=> o_port_ready_out_oe_n)
    else $error("ready pin driven under output disable");
  host_interrupt_out_float_a: assert property (!off_n_q |=> o_host_interrupt_out_oe_n)
    else $error("interrupt pin driven under output disable");
  strap_lock_a: assert property ($past(cap_done_r) |-> $stable(port_en_r))
    else $error("port enable changed after capture");
  strap_take_a: assert property (
    (!cap_done_r && strap_cnt_r == 3'(STRAP_SETTLE)) |=> port_en_r == $past(strap_q))
    else $error("strap not taken at capture");
  disabled_idle_a: assert property (!port_en_r |-> state_r == hpi_pkg::ST_IDLE)
    else $error("transfer started on disabled port");
  strobe_start_a: assert property (
    (state_r == hpi_pkg::ST_IDLE && state_nxt != hpi_pkg::ST_IDLE) |-> xfer_q)
    else $error("transfer started without chip select and strobe");
  // ready may rise on the edge after the acknowledge
  ready_low_a: assert property (
    (state_r == hpi_pkg::ST_MEM && !i_mem_ack) |=> !o_port_ready_out)
    else $error("ready high during memory cycle");
  wide_addr_a: assert property (
    (start && wide_q) |=> o_mem_req && o_mem_addr == $past(addr_q)
    && o_mem_we == !$past(rw_q))
    else $error("wide access lost address or direction");
  addr_latch_a: assert property (
    (as_fall && state_r == hpi_pkg::ST_IDLE && !start) |=> haddr_r ==
    hpi_pkg::merge_byte($past(haddr_r), $past(narrow_q), $past(bil_q)))
    else $error("address strobe did not latch address");
  wide_no_int_a: assert property ((wide_act && cap_done_r) |=> o_host_interrupt_out)
    else $error("interrupt shown in wide mode");
  timer_route_a: assert property (
    (cap_done_r && !port_en_r && route_en) |=>
    o_host_interrupt_out == $past(i_second_timer_output))
    else $error("timer output not routed");

  mux_write_c: cover property (host_control_register_wr);
  wide_read_c: cover property (wide_act && state_r == hpi_pkg::ST_MEM && !o_mem_we);
  data_inc_c:  cover property (state_r == hpi_pkg::ST_HOLD && !xfer_q
                               && sel_r == hpi_pkg::SEL_DATA_INC && bil_r);
  bus_write_c: cover property (wr_host_interrupt_out);
endmodule : host_port_pin_interface

// [hdl/hpi_pkg.sv]
// constants, types and byte helpers shared by the host port block
package hpi_pkg;

  // register bus word indices (byte address is four times the index)
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_HOST_INTERRUPT_OUT = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;

  // control register fields
  localparam int unsigned CTRL_ROUTE_BIT    = 0;
  localparam int unsigned CTRL_GPIO_OUT_LSB = 8;
  localparam int unsigned CTRL_GPIO_DIR_LSB = 16;
  localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

  // interrupt register fields
  localparam int unsigned HOST_INTERRUPT_OUT_FLAG_BIT   = 0;
  localparam int unsigned HOST_INTERRUPT_OUT_DSPINT_BIT = 1;

  // status register fields
  localparam int unsigned STAT_EN_BIT   = 0;
  localparam int unsigned STAT_WIDE_BIT = 1;
  localparam int unsigned STAT_RDY_BIT  = 2;
  localparam int unsigned STAT_GPIO_LSB = 8;
  localparam int unsigned STAT_ADDR_LSB = 16;

  // host register selection codes
  localparam logic [1:0] SEL_CTRL     = 2'h0;
  localparam logic [1:0] SEL_DATA_INC = 2'h1;
  localparam logic [1:0] SEL_ADDR     = 2'h2;
  localparam logic [1:0] SEL_DATA     = 2'h3;

  // host control register fields
  localparam int unsigned HOST_CONTROL_REGISTER_DSPINT_BIT = 1;
  localparam int unsigned HOST_CONTROL_REGISTER_HOST_INTERRUPT_OUT_BIT   = 2;

  // cycles after reset release before the strap is taken
  localparam int unsigned STRAP_SETTLE = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MEM  = 2'b01,
    ST_HOLD = 2'b10
  } xfer_state_t;

  // first byte of a pair is the high byte
  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic second);
    pick_byte = second ? word[7:0] : word[15:8];
  endfunction : pick_byte

  function automatic logic [15:0] merge_byte(input logic [15:0] word, input logic [7:0] b,
                                             input logic second);
    merge_byte = second ? {word[15:8], b} : {b, word[7:0]};
  endfunction : merge_byte

endpackage : hpi_pkg

// [hdl/pin_sync.sv]
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module pin_sync #(
  parameter int unsigned      WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  // pins in, synchronised out
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  if (WIDTH < 1) begin : g_chk
    $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : pin_sync

// [verif/host_cpu_model.sv]
// host processor model that drives the parallel port pins
`timescale 1ns/10ps
module host_cpu_model (
  // clock
  input  wire logic       i_clk,
  // port pins and hang flag
  input  wire logic       i_ready,
  input  wire logic [7:0] i_hd,
  output logic      [7:0] o_hd,
  output logic      [1:0] o_sel,
  output logic            o_ident,
  output logic            o_cs_n,
  output logic            o_ds_a_n,
  output logic            o_ds_b_n,
  output logic            o_as_n,
  output logic            o_dir,
  output logic            o_hang
);
  initial begin
    o_hd = 8'h00;
    o_sel = 2'h0;
    o_ident = 1'b0;
    o_cs_n = 1'b1;
    o_ds_a_n = 1'b1;
    o_ds_b_n = 1'b1;
    o_as_n = 1'b1;
    o_dir = 1'b1;
    o_hang = 1'b0;
  end
  task automatic wait_ready();
    int k;
    k = 0;
    while (i_ready !== 1'b1 && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 200) o_hang <= 1'b1;
  endtask : wait_ready
  task automatic xfer(input logic [1:0] sel, input logic id, input logic rd,
                      input logic [7:0] wd, output logic [7:0] q);
    wait_ready();
    @(posedge i_clk);
    o_sel <= sel;
    o_ident <= id;
    o_dir <= rd;
    o_cs_n <= 1'b0;
    o_hd <= rd ? ~o_hd : wd;
    repeat (2) @(posedge i_clk);
    // writes on one strobe, reads on the other
    if (rd) o_ds_b_n <= 1'b0;
    else o_ds_a_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    wait_ready();
    repeat (2) @(posedge i_clk);
    q = i_hd;
    o_ds_a_n <= 1'b1;
    o_ds_b_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_cs_n <= 1'b1;
    // a released bus must not keep showing the old value
    o_hd <= ~wd;
    repeat (3) @(posedge i_clk);
  endtask : xfer
  task automatic astrobe(input logic id, input logic [7:0] a);
    wait_ready();
    @(posedge i_clk);
    o_ident <= id;
    o_hd <= a;
    repeat (2) @(posedge i_clk);
    o_as_n <= 1'b0;
    repeat (3) @(posedge i_clk);
    o_as_n <= 1'b1;
    repeat (3) @(posedge i_clk);
  endtask : astrobe
endmodule : host_cpu_model

// [verif/host_port_pin_interface_tb_top.sv]
// self-checking bench for the parallel host port block
`timescale 1ns/10ps
module host_port_pin_interface_tb_top;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        strap = 1'b1;
  logic        wide = 1'b0;
  logic        off_n = 1'b1;
  logic        tmr = 1'b0;
  logic        ack = 1'b0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  adr = 2'h0;
  logic [15:0] waddr = 16'h0000;
  logic [15:0] wdat = 16'h0000;
  logic [15:0] rdat = 16'h0000;
  logic [31:0] wd32 = 32'h0;
  logic [31:0] q32, rdata;
  logic [15:0] m_addr, m_wd, maddr, mwd, wd_o;
  logic [15:0] wd_seen = 16'h0000;
  logic        m_we, mwe, req, dsp_int, waitreq, hang, wd_oe_n;
  logic        ready, ready_oe_n, host_interrupt_out, host_interrupt_out_oe_n, id, cs_n, ds_a_n, ds_b_n, as_n, dir;
  logic [7:0]  hd, hd_o, hd_oe_n, host_hd;
  logic [1:0]  sel;
  int          n_errors = 0;
  int          n_tests = 0;

  always #4 clk = ~clk;
  assign hd = (hd_o & ~hd_oe_n) | (host_hd & hd_oe_n);

  host_port_pin_interface dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_select_bit0(sel[0]), .i_reg_select_bit1(sel[1]),
    .i_byte_order_ident(id), .i_port_chip_select_n(cs_n), .i_data_strobe_a_n(ds_a_n),
    .i_data_strobe_b_n(ds_b_n), .i_addr_strobe_n(as_n), .i_transfer_direction(dir),
    .i_port_enable_strap(strap), .i_wide_mode_select(wide), .i_outputs_off_n(off_n),
    .i_wide_address_pins(waddr), .i_narrow_host_data(hd), .o_narrow_host_data(hd_o),
    .o_narrow_host_data_oe_n(hd_oe_n), .i_wide_data(wdat), .o_wide_data(wd_o),
    .o_wide_data_oe_n(wd_oe_n), .o_port_ready_out(ready), .o_port_ready_out_oe_n(ready_oe_n),
    .o_host_interrupt_out(host_interrupt_out), .o_host_interrupt_out_oe_n(host_interrupt_out_oe_n),
    .i_second_timer_output(tmr), .o_mem_req(req), .o_mem_we(mwe), .o_mem_addr(maddr),
    .o_mem_wdata(mwd), .i_mem_ack(ack), .i_mem_rdata(rdat), .o_dsp_int(dsp_int),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd32),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));

  host_cpu_model host (
    .i_clk(clk), .i_ready(ready), .i_hd(hd), .o_hd(host_hd), .o_sel(sel), .o_ident(id),
    .o_cs_n(cs_n), .o_ds_a_n(ds_a_n), .o_ds_b_n(ds_b_n), .o_as_n(as_n), .o_dir(dir),
    .o_hang(hang));

  // memory answers one cycle after a request, read data is the inverted address
  always @(posedge clk) begin
    ack <= req & ~ack;
    if (req & ~ack) begin
      rdat <= ~maddr;
      m_addr <= maddr;
      m_we <= mwe;
      m_wd <= mwd;
    end
    // keep the last word the block drove on the wide data pins
    if (!wd_oe_n) wd_seen <= wd_o;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge hang) begin
    n_errors++;
    report_and_stop();
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wd32 <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 50);
    q32 = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k >= 50) begin
      n_errors++;
      report_and_stop();
    end
  endtask : av

  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (4) @(posedge clk);
    chk({ready, ready_oe_n, host_interrupt_out, host_interrupt_out_oe_n}, 4'b0010);
    rst_n <= 1'b1;
    repeat (12) @(posedge clk);
  endtask : do_reset

  task automatic t_mux();
    logic [7:0] q;
    host.xfer(hpi_pkg::SEL_ADDR, 1'b0, 1'b0, 8'h00, q);
    host.xfer(hpi_pkg::SEL_ADDR, 1'b1, 1'b0, 8'h40, q);
    host.xfer(hpi_pkg::SEL_DATA_INC, 1'b0, 1'b0, 8'hab, q);
    host.xfer(hpi_pkg::SEL_DATA_INC, 1'b1, 1'b0, 8'hcd, q);
    chk({m_we, m_addr, m_wd}, {1'b1, 16'h0040, 16'habcd});
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[31:16], 16'h0041);
    host.xfer(hpi_pkg::SEL_DATA, 1'b0, 1'b1, 8'h00, q);
    chk({m_we, m_addr, q}, {1'b0, 16'h0041, 8'hff});
    host.xfer(hpi_pkg::SEL_DATA, 1'b1, 1'b1, 8'h00, q);
    chk(q, 8'hbe);
    host.astrobe(1'b0, 8'h12);
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[31:16], 16'h1241);
    $display("muxed transfers done");
  endtask : t_mux

  task automatic t_int();
    logic [7:0] q;
    av(1'b1, hpi_pkg::REG_HOST_INTERRUPT_OUT, 32'h1);
    repeat (2) @(posedge clk);
    chk(host_interrupt_out, 1'b0);
    host.xfer(hpi_pkg::SEL_CTRL, 1'b0, 1'b0, 8'h00, q);
    host.xfer(hpi_pkg::SEL_CTRL, 1'b1, 1'b0, 8'h06, q);
    chk({host_interrupt_out, dsp_int}, 2'b11);
    off_n <= 1'b0;
    repeat (4) @(posedge clk);
    chk({ready_oe_n, host_interrupt_out_oe_n}, 2'b11);
    off_n <= 1'b1;
    $display("interrupt pins done");
  endtask : t_int

  task automatic t_wide();
    logic [7:0] q;
    av(1'b1, hpi_pkg::REG_HOST_INTERRUPT_OUT, 32'h1);
    wide <= 1'b1;
    waddr <= 16'h1234;
    wdat <= 16'h5a5a;
    av(1'b1, hpi_pkg::REG_CTRL, 32'h00ff_a500);
    repeat (4) @(posedge clk);
    chk({host_interrupt_out, dsp_int, hd_oe_n, hd_o}, {1'b1, 1'b0, 8'h00, 8'ha5});
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[1:0], 2'b11);
    host.xfer(hpi_pkg::SEL_DATA, 1'b0, 1'b0, 8'h00, q);
    chk({m_we, m_addr, m_wd}, {1'b1, 16'h1234, 16'h5a5a});
    waddr <= 16'h2000;
    host.xfer(hpi_pkg::SEL_DATA, 1'b0, 1'b1, 8'h00, q);
    chk({m_we, m_addr}, {1'b0, 16'h2000});
    chk(wd_seen, 16'hdfff);
    av(1'b1, hpi_pkg::REG_CTRL, 32'h0);
    wide <= 1'b0;
    $display("wide mode done");
  endtask : t_wide

  task automatic t_off();
    do_reset(1'b0);
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[0], 1'b0);
    av(1'b1, hpi_pkg::REG_CTRL, 32'h1);
    tmr <= 1'b1;
    repeat (3) @(posedge clk);
    chk(host_interrupt_out, 1'b1);
    tmr <= 1'b0;
    strap <= 1'b1;
    repeat (8) @(posedge clk);
    chk(host_interrupt_out, 1'b0);
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[0], 1'b0);
    $display("disabled port done");
  endtask : t_off

  initial begin
    do_reset(1'b1);
    av(1'b0, hpi_pkg::REG_STAT, 32'h0);
    chk(q32[2:0], 3'b101);
    av(1'b0, 2'h3, 32'h0);
    chk(q32, 32'h0);
    t_mux();
    t_int();
    t_wide();
    t_off();
    report_and_stop();
  end
endmodule : host_port_pin_interface_tb_top
